// ### rtl/wake_ctrl_map.vh
// Constants for the wake-up controller: register offsets, field positions,
// reset values and timing counts. Assumes an APB slave with 32-bit data.
// ****************************************************************
// ****************************************************************
`ifndef WAKE_CTRL_MAP_VH
`define WAKE_CTRL_MAP_VH

`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_WAKE_EN 12'h008
`define OFF_DEEP_CFG 12'h00c
`define OFF_TIMER 12'h010
`define OFF_IRQ_STAT 12'h014
`define OFF_IRQ_MASK 12'h018
`define OFF_PIN_CFG 12'h01c

// Control fields
`define CTRL_SLEEP_REQ 0
`define CTRL_DEEP_REQ 1
`define CTRL_MONITOR 2
`define CTRL_WAKE_LOCK 3
`define CTRL_RESET_DEFAULT 4'h4

// Deep wake configuration fields
`define DEEP_TIMER_EN 0
`define DEEP_PIN_A_EN 1
`define DEEP_PIN_B_EN 2
`define DEEP_ANALOG_EN 3
`define DEEP_ANALOG_SEL 4

// Pin configuration fields
`define PIN_GATED_LO 0
`define PIN_GATED_HI 3
`define PIN_SHARED_RESET_OUT 4
`define PIN_SHARED_MUX 5

// Interrupt status fields
`define IRQ_WAKE 0
`define IRQ_INSERT 1
`define IRQ_REMOVE 2
`define IRQ_DEEP_WAKE 3
`define IRQ_WIDTH 4

// Power states
`define ST_ACTIVE 2'h0
`define ST_SLEEP 2'h1
`define ST_DEEP 2'h2

// Timer tick: 1 us per tick
`define TICK_NS 1000
`define CLK_NS 10
`define TICK_CYCLES (`TICK_NS / `CLK_NS)

`endif

// ### rtl/pin_sync.v
// Two-flop synchroniser with edge detect behind it.
// Assumes the input is asynchronous to pclk.
`timescale 1ns/10ps
module pin_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire pclk,
	input wire presetn,
	input wire [W-1:0] din,
	output wire [W-1:0] level,
	output wire [W-1:0] rise,
	output wire [W-1:0] fall
);
	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;
	reg [W-1:0] last_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= INIT;
			sync_reg <= INIT;
			last_reg <= INIT;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise = sync_reg & ~last_reg;
	assign fall = ~sync_reg & last_reg;
endmodule

// ### rtl/low_power_wakeup_controller.v
// Wake-up controller: sleep and deep low-power states, wake sources,
// card detect events, pin availability, APB registers and one interrupt.
// Assumes wake pins are asynchronous; internal requests are on pclk.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
`include "wake_ctrl_map.vh"
module low_power_wakeup_controller (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire wake_pin_a,
	input wire wake_pin_b,
	input wire wake_pin_c,
	input wire deep_wake_pin_a,
	input wire deep_wake_pin_b,
	input wire terminal_ready_in_n,
	input wire card_presence_detect,
	input wire primary_uart_request_to_send,
	input wire power_on_n,
	input wire analog_wake_input_a,
	input wire analog_wake_input_b,
	input wire [3:0] gated_pin_in,
	input wire shared_reset_out_pin_in,
	input wire usb_suspend_exit,
	input wire modem_message_exchange,
	output wire [1:0] power_state,
	output wire wake_pulse,
	output wire card_present,
	output wire card_detect_pull_up,
	output wire [4:0] pin_pull_up,
	output wire [4:0] pin_pull_down,
	output wire [3:0] gated_pin_level,
	output wire shared_pin_level,
	output wire shared_pin_gpio_avail,
	output wire flow_control_request,
	output wire irq
);
	// ****************************************************************
	// Synchronisers
	// ****************************************************************
	wire [4:0] wp_lvl;
	wire [4:0] wp_rise;
	wire [4:0] wp_fall;
	wire [1:0] misc_lvl;
	wire [1:0] misc_rise;
	wire [1:0] misc_fall;
	wire [3:0] other_lvl;
	wire [4:0] gp_lvl;

	pin_sync #(.W(5), .INIT(5'h00)) u_wake_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({deep_wake_pin_b, deep_wake_pin_a, wake_pin_c, wake_pin_b, wake_pin_a}),
		.level(wp_lvl),
		.rise(wp_rise),
		.fall(wp_fall)
	);

	// Bit 0 terminal ready idles high; bit 1 card detect idles low, holder empty
	pin_sync #(.W(2), .INIT(2'h1)) u_misc_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({card_presence_detect, terminal_ready_in_n}),
		.level(misc_lvl),
		.rise(misc_rise),
		.fall(misc_fall)
	);

	pin_sync #(.W(4), .INIT(4'h1)) u_other_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({primary_uart_request_to_send, analog_wake_input_b, analog_wake_input_a, power_on_n}),
		.level(other_lvl),
		.rise(),
		.fall()
	);

	pin_sync #(.W(5), .INIT(5'h00)) u_gpio_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din({shared_reset_out_pin_in, gated_pin_in}),
		.level(gp_lvl),
		.rise(),
		.fall()
	);

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg [3:0] ctrl_reg;
	reg [6:0] wake_en_reg;
	reg [5:0] deep_cfg_reg;
	reg [31:0] timer_reg;
	reg [31:0] timer_cnt_reg;
	reg [6:0] tick_reg;
	reg [3:0] irq_stat_reg;
	reg [3:0] irq_mask_reg;
	reg [5:0] pin_cfg_reg;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg wake_pulse_reg;
	reg [31:0] prdata_reg;

	wire wr = psel & penable & pwrite;
	wire rd_setup = psel & ~penable & ~pwrite;

	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `OFF_CTRL) || (a == `OFF_STATUS) || (a == `OFF_WAKE_EN) ||
				(a == `OFF_DEEP_CFG) || (a == `OFF_TIMER) || (a == `OFF_IRQ_STAT) ||
				(a == `OFF_IRQ_MASK) || (a == `OFF_PIN_CFG);
		end
	endfunction

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~is_mapped(paddr);
	assign prdata = prdata_reg;

	function wr_to;
		input [11:0] off;
		begin
			wr_to = wr & (paddr == off);
		end
	endfunction

	function [31:0] read_word;
		input [11:0] a;
		begin
			if (a == `OFF_CTRL)
				read_word = {28'h0, ctrl_reg};
			else if (a == `OFF_STATUS)
				read_word = {21'h0, misc_lvl, wp_lvl, 2'h0, state_reg};
			else if (a == `OFF_WAKE_EN)
				read_word = {25'h0, wake_en_reg};
			else if (a == `OFF_DEEP_CFG)
				read_word = {26'h0, deep_cfg_reg};
			else if (a == `OFF_TIMER)
				read_word = timer_reg;
			else if (a == `OFF_IRQ_STAT)
				read_word = {28'h0, irq_stat_reg};
			else if (a == `OFF_IRQ_MASK)
				read_word = {28'h0, irq_mask_reg};
			else if (a == `OFF_PIN_CFG)
				read_word = {26'h0, pin_cfg_reg};
			else
				read_word = 32'h0000_0000;
		end
	endfunction

	// ****************************************************************
	// Wake sources
	// ****************************************************************
	wire [6:0] sleep_edge = {misc_rise[1] | misc_fall[1], misc_rise[0] | misc_fall[0],
		wp_rise | wp_fall};
	wire sleep_pin_wake = ctrl_reg[`CTRL_MONITOR] & |(sleep_edge & wake_en_reg);
	wire internal_wake = ctrl_reg[`CTRL_WAKE_LOCK] | usb_suspend_exit | modem_message_exchange |
		~misc_lvl[0];
	wire sleep_wake = (state_reg == `ST_SLEEP) & (sleep_pin_wake | internal_wake);

	wire timer_hit = deep_cfg_reg[`DEEP_TIMER_EN] & (timer_cnt_reg >= timer_reg);
	wire analog_hit = deep_cfg_reg[`DEEP_ANALOG_EN] &
		(deep_cfg_reg[`DEEP_ANALOG_SEL] ? other_lvl[2] : other_lvl[1]);
	wire deep_src = timer_hit | analog_hit | ~other_lvl[0] |
		(deep_cfg_reg[`DEEP_PIN_A_EN] & (wp_rise[3] | wp_fall[3])) |
		(deep_cfg_reg[`DEEP_PIN_B_EN] & (wp_rise[4] | wp_fall[4]));
	wire deep_wake = (state_reg == `ST_DEEP) & deep_src;

	always @* begin
		state_next = state_reg;
		case (state_reg)
			`ST_ACTIVE: begin
				if (ctrl_reg[`CTRL_DEEP_REQ])
					state_next = `ST_DEEP;
				else if (ctrl_reg[`CTRL_SLEEP_REQ] & misc_lvl[0] & ~ctrl_reg[`CTRL_WAKE_LOCK])
					state_next = `ST_SLEEP;
			end
			`ST_SLEEP: begin
				if (sleep_wake)
					state_next = `ST_ACTIVE;
			end
			`ST_DEEP: begin
				if (deep_wake)
					state_next = `ST_ACTIVE;
			end
			default: state_next = `ST_ACTIVE;
		endcase
	end

	// ****************************************************************
	// Sequential logic
	// ****************************************************************
	wire [3:0] irq_set = {deep_wake, misc_fall[1], misc_rise[1], sleep_wake};
	wire leaving = (state_next == `ST_ACTIVE) & (state_reg != `ST_ACTIVE);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= `ST_ACTIVE;
			wake_pulse_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			wake_pulse_reg <= leaving;
		end
	end

	// Request bits drop on wake, so a served request cannot re-enter at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `CTRL_RESET_DEFAULT;
		end else if (leaving) begin
			ctrl_reg[`CTRL_SLEEP_REQ] <= 1'b0;
			ctrl_reg[`CTRL_DEEP_REQ] <= 1'b0;
		end else if (wr_to(`OFF_CTRL)) begin
			ctrl_reg <= pwdata[3:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_en_reg <= 7'h7f;
			deep_cfg_reg <= 6'h00;
			timer_reg <= 32'hffff_ffff;
			pin_cfg_reg <= 6'h00;
			irq_mask_reg <= 4'h0;
		end else begin
			if (wr_to(`OFF_WAKE_EN))
				wake_en_reg <= pwdata[6:0];
			if (wr_to(`OFF_DEEP_CFG))
				deep_cfg_reg <= pwdata[5:0];
			if (wr_to(`OFF_TIMER))
				timer_reg <= pwdata;
			if (wr_to(`OFF_PIN_CFG))
				pin_cfg_reg <= pwdata[5:0];
			if (wr_to(`OFF_IRQ_MASK))
				irq_mask_reg <= pwdata[3:0];
		end
	end

	// ****************************************************************
	// Interrupt status
	// ****************************************************************
	// An event in the clearing cycle wins over the clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= 4'h0;
		end else if (wr_to(`OFF_IRQ_STAT)) begin
			irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | irq_set;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_set;
		end
	end

	// ****************************************************************
	// Deep timer
	// ****************************************************************
	// Counts ticks only in deep state and saturates rather than wrap
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_cnt_reg <= 32'h0000_0000;
			tick_reg <= 7'h00;
		end else if (state_reg != `ST_DEEP) begin
			timer_cnt_reg <= 32'h0000_0000;
			tick_reg <= 7'h00;
		end else if ({25'h0, tick_reg} == `TICK_CYCLES - 1) begin
			tick_reg <= 7'h00;
			if (timer_cnt_reg != 32'hffff_ffff)
				timer_cnt_reg <= timer_cnt_reg + 32'h0000_0001;
		end else begin
			tick_reg <= tick_reg + 7'h01;
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	// Loaded in the setup cycle so it stands through the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_reg <= read_word(paddr);
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign power_state = state_reg;
	assign wake_pulse = wake_pulse_reg;
	assign card_present = misc_lvl[1];
	assign card_detect_pull_up = 1'b1;
	assign pin_pull_up = 5'h00;
	assign pin_pull_down = 5'h00;
	assign gated_pin_level = gp_lvl[3:0] & pin_cfg_reg[`PIN_GATED_HI:`PIN_GATED_LO];
	assign shared_pin_gpio_avail = ~(pin_cfg_reg[`PIN_SHARED_RESET_OUT] | pin_cfg_reg[`PIN_SHARED_MUX]);
	assign shared_pin_level = gp_lvl[4] & shared_pin_gpio_avail;
	assign flow_control_request = other_lvl[3];
	assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// ### tb/wake_ctrl_checker_assertions.sv
// Port assertions for the wake-up controller.
// Assumes it is bound into low_power_wakeup_controller, pclk domain only.
`timescale 1ns/10ps
`include "wake_ctrl_map.vh"
module wake_ctrl_checker (
	input wire pclk,
	input wire presetn,
	input wire [1:0] power_state,
	input wire wake_pulse,
	input wire card_present,
	input wire card_presence_detect,
	input wire card_detect_pull_up,
	input wire [4:0] pin_pull_up,
	input wire [4:0] pin_pull_down,
	input wire shared_pin_level,
	input wire shared_pin_gpio_avail,
	input wire terminal_ready_in_n,
	input wire usb_suspend_exit,
	input wire modem_message_exchange,
	input wire power_on_n
);
// ********
// Checks
// ********
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
property p_pull; card_detect_pull_up && pin_pull_up == 5'h00 && pin_pull_down == 5'h00; endproperty
a_pull: assert property (p_pull) else $error("pull setting wrong");
property p_card; $stable(card_presence_detect) [*2] |-> card_present == card_presence_detect; endproperty
a_card: assert property (p_card) else $error("card level wrong");
property p_term; (!terminal_ready_in_n) [*4] |-> power_state != `ST_SLEEP; endproperty
a_term: assert property (p_term) else $error("sleep while terminal ready");
property p_src; power_state == `ST_SLEEP && (usb_suspend_exit || modem_message_exchange) |=> power_state == `ST_ACTIVE;
endproperty
a_src: assert property (p_src) else $error("internal wake missed");
property p_deep; (power_state == `ST_DEEP && !power_on_n) [*3] |=> power_state == `ST_ACTIVE; endproperty
a_deep: assert property (p_deep) else $error("power-on wake missed");
property p_pulse; power_state != `ST_ACTIVE ##1 power_state == `ST_ACTIVE |-> wake_pulse; endproperty
a_pulse: assert property (p_pulse) else $error("wake pulse missing");
property p_pulse_src; wake_pulse |-> $past(power_state, 1) != `ST_ACTIVE; endproperty
a_pulse_src: assert property (p_pulse_src) else $error("stray wake pulse");
property p_shared; !shared_pin_gpio_avail |-> !shared_pin_level; endproperty
a_shared: assert property (p_shared) else $error("shared pin leaks");
endmodule
bind low_power_wakeup_controller wake_ctrl_checker chk_u (.pclk, .presetn, .power_state, .wake_pulse,
	.card_present, .card_presence_detect, .card_detect_pull_up, .pin_pull_up, .pin_pull_down, .shared_pin_level,
	.shared_pin_gpio_avail, .terminal_ready_in_n, .usb_suspend_exit, .modem_message_exchange, .power_on_n);

// ### tb/host_partner.sv
// Host and card holder model: card detect line and flow-control input.
// Assumes card_in from the bench means a card sits in the holder.
`timescale 1ns/10ps
module host_partner (
	input wire card_in,
	output wire card_presence_detect,
	output wire primary_uart_request_to_send
);
// Empty holder grounds the detect line
assign card_presence_detect = card_in ? 1'b1 : 1'b0;
// Two-wire use keeps flow control off
assign primary_uart_request_to_send = 1'b0;
endmodule

// ### tb/low_power_wakeup_controller_tb_top.sv
// Self-checking bench for the wake-up controller.
// Assumes the map header and the host_partner model.
`timescale 1ns/10ps
`include "wake_ctrl_map.vh"
module low_power_wakeup_controller_tb_top;
reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h0, rd = 32'h0, seed = 32'he7109f6f;
reg [4:0] wp = 5'h00;
reg [3:0] gpi = 4'h0;
reg tr_n = 1, pon_n = 1, ana = 0, anb = 0, srp = 0, usb = 0, mdm = 0, card = 0, er = 0;
integer err_count = 0, cmp_count = 0, n, j;
wire [31:0] prdata;
wire [1:0] ps;
wire [3:0] gpl;
wire [4:0] pu, pd;
wire pready, pslverr, cpres, cpu, spl, spa, fcr, irq, cpd, rts;
host_partner part_u (.card_in(card), .card_presence_detect(cpd), .primary_uart_request_to_send(rts));
low_power_wakeup_controller dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .wake_pin_a(wp[0]), .wake_pin_b(wp[1]), .wake_pin_c(wp[2]), .deep_wake_pin_a(wp[3]),
	.deep_wake_pin_b(wp[4]), .terminal_ready_in_n(tr_n), .card_presence_detect(cpd),
	.primary_uart_request_to_send(rts), .power_on_n(pon_n), .analog_wake_input_a(ana), .analog_wake_input_b(anb),
	.gated_pin_in(gpi), .shared_reset_out_pin_in(srp), .usb_suspend_exit(usb), .modem_message_exchange(mdm),
	.power_state(ps), .wake_pulse(), .card_present(cpres), .card_detect_pull_up(cpu), .pin_pull_up(pu),
	.pin_pull_down(pd), .gated_pin_level(gpl), .shared_pin_level(spl), .shared_pin_gpio_avail(spa),
	.flow_control_request(fcr), .irq);
// ********
// Helpers
// ********
always #5 pclk = ~pclk;
function [31:0] lfsr(input [31:0] v);
	lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task chk(input [31:0] got, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
endtask
task conclude;
	begin
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
	integer k;
	begin
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge pclk);
			k = k + 1;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			err_count = err_count + 1;
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	end
endtask
// Waits a bounded time for a power state, then compares
task ws(input [1:0] s);
	integer k;
	begin
		k = 0;
		@(negedge pclk);
		while (ps !== s && k < 600) begin
			@(negedge pclk);
			k = k + 1;
		end
		chk(ps, s);
	end
endtask
task poke(input integer s);
	begin
		@(posedge pclk);
		if (s < 5)
			wp[s] <= ~wp[s];
		if (s == 5)
			tr_n <= 0;
		if (s == 6)
			card <= ~card;
		usb <= (s == 7);
		mdm <= (s == 8);
		if (s == 9)
			apb(1, `OFF_CTRL, 32'hc);
		@(posedge pclk);
		usb <= 0;
		mdm <= 0;
	end
endtask
task stay(input [1:0] s);
	begin
		repeat (12) @(negedge pclk);
		chk(ps, s);
	end
endtask
// ********
// Scenarios
// ********
initial begin
	#500000;
	err_count = err_count + 1;
	conclude;
end
initial begin
	repeat (20) @(posedge pclk);
	presetn <= 1;
	apb(0, `OFF_CTRL, 0);
	chk(rd, `CTRL_RESET_DEFAULT);
	apb(0, `OFF_WAKE_EN, 0);
	chk(rd, 32'h7f);
	apb(0, `OFF_TIMER, 0);
	chk(rd, 32'hffffffff);
	apb(0, 12'h020, 0);
	chk({er, rd[30:0]}, 32'h80000000);
	chk({fcr, pu, pd, cpu}, 32'h1);
	for (n = 0; n < 30; n = n + 1) begin
		seed = lfsr(seed);
		apb(1, `OFF_CTRL, 32'h5);
		ws(`ST_SLEEP);
		poke(n < 10 ? n : seed % 10);
		ws(`ST_ACTIVE);
		@(posedge pclk);
		tr_n <= 1;
		repeat (4) @(posedge pclk);
	end
	apb(1, `OFF_WAKE_EN, 32'h7e);
	apb(1, `OFF_CTRL, 32'h5);
	poke(0);
	stay(`ST_SLEEP);
	poke(7);
	ws(`ST_ACTIVE);
	apb(1, `OFF_WAKE_EN, 32'h7f);
	@(posedge pclk);
	tr_n <= 0;
	apb(1, `OFF_CTRL, 32'h5);
	stay(`ST_ACTIVE);
	@(posedge pclk);
	tr_n <= 1;
	ws(`ST_SLEEP);
	apb(1, `OFF_DEEP_CFG, 32'h18);
	@(posedge pclk);
	anb <= 1;
	stay(`ST_SLEEP);
	@(posedge pclk);
	anb <= 0;
	poke(8);
	ws(`ST_ACTIVE);
	apb(1, `OFF_DEEP_CFG, 32'h08);
	apb(1, `OFF_DEEP_CFG, 32'h18);
	apb(1, `OFF_CTRL, 32'h6);
	ws(`ST_DEEP);
	@(posedge pclk);
	ana <= 1;
	usb <= 1;
	wp[0] <= ~wp[0];
	stay(`ST_DEEP);
	@(posedge pclk);
	ana <= 0;
	usb <= 0;
	anb <= 1;
	ws(`ST_ACTIVE);
	@(posedge pclk);
	anb <= 0;
	for (j = 0; j < 5; j = j + 1) begin
		apb(1, `OFF_DEEP_CFG, j == 0 ? 0 : 1 << (j - 1));
		apb(1, `OFF_TIMER, 32'h2);
		apb(1, `OFF_CTRL, 32'h6);
		ws(`ST_DEEP);
		@(posedge pclk);
		pon_n <= (j != 0);
		ana <= (j == 4);
		if (j == 2 || j == 3)
			wp[j + 1] <= ~wp[j + 1];
		ws(`ST_ACTIVE);
		@(posedge pclk);
		pon_n <= 1;
		ana <= 0;
		repeat (4) @(posedge pclk);
	end
	@(posedge pclk);
	card <= 0;
	apb(1, `OFF_IRQ_MASK, 0);
	apb(1, `OFF_IRQ_STAT, 32'hf);
	@(posedge pclk);
	card <= 1;
	repeat (6) @(posedge pclk);
	apb(0, `OFF_IRQ_STAT, 0);
	chk({irq, rd[30:0]}, 32'h2);
	apb(1, `OFF_IRQ_MASK, 32'h2);
	@(negedge pclk);
	chk(irq, 1);
	apb(1, `OFF_IRQ_STAT, 32'h2);
	@(negedge pclk);
	chk(irq, 0);
	@(posedge pclk);
	card <= 0;
	repeat (6) @(posedge pclk);
	apb(0, `OFF_IRQ_STAT, 0);
	chk(rd, 32'h4);
	gpi <= seed[3:0];
	srp <= 1;
	apb(1, `OFF_PIN_CFG, 0);
	repeat (3) @(negedge pclk);
	chk({spa, spl, gpl}, 32'h30);
	apb(1, `OFF_PIN_CFG, 32'h1f);
	repeat (3) @(negedge pclk);
	chk({spa, spl, gpl}, {28'h0, seed[3:0]});
	apb(1, `OFF_PIN_CFG, 32'h20);
	repeat (3) @(negedge pclk);
	chk({spa, spl}, 0);
	apb(0, `OFF_STATUS, 0);
	chk(rd, {21'h0, card, tr_n, wp, 4'h0});
	chk(cpres, card);
	conclude;
end
endmodule
